// ---- hdl/tzc_pkg.sv ----
// Purpose: Shared constants and types for the timer configuration slice.
// Assumes: One 8-bit control register on a plain address port.
// Notes: Mode codes follow the lower mode field of the second control register.

package tzc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] CTL0_ADDR = 12'hf06;
  localparam logic [7:0] CTL0_RESET = 8'h00;

  // ----------------------------------------
  // Interrupt configuration settings
  // ----------------------------------------
  localparam logic [1:0] IRQ_CFG_ALT = 2'h2;
  localparam logic [1:0] IRQ_CFG_RELOAD = 2'h3;

  // Four-bit operating mode selector.
  typedef enum logic [3:0] {
    MODE_ONE_SHOT = 4'h0,
    MODE_CONTINUOUS = 4'h1,
    MODE_COUNTER = 4'h2,
    MODE_PWM = 4'h3,
    MODE_CAPTURE = 4'h4,
    MODE_COMPARE = 4'h5,
    MODE_GATED = 4'h6,
    MODE_CAP_CMP = 4'h7,
    MODE_DUAL_PWM = 4'h8,
    MODE_CAP_RESTART = 4'h9,
    MODE_CMP_COUNTER = 4'ha,
    MODE_TRIG_ONE_SHOT = 4'hb
  } tzc_mode_t;

  // Layout of the first control register, bit 7 down to bit 0.
  typedef struct packed {
    logic modeHigh;
    logic [1:0] irqCfg;
    logic inSel;
    logic [2:0] delay;
    logic capFlag;
  } tzc_ctl_t;

  // Events arriving from the counter datapath.
  typedef struct packed {
    logic reload;
    logic capture;
    logic pwmMatch;
  } tzc_evt_t;

endpackage

// ---- hdl/tzc_timer_config.sv ----
// Purpose: Control register, interrupt selection, input select and dead time.
// Assumes: Events are one-cycle pulses on core_clk from the timer datapath.
// Notes: Output pair is active high; polarity only steers the gate edge.
//
// Implementation choice: the strobed register port.

`timescale 1ns/1ps
`default_nettype none

module tzc_timer_config #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Timer datapath side.
  input wire logic [2:0] modeLow,
  input wire logic ioPolarity,
  input wire tzc_pkg::tzc_evt_t evt,
  output logic [3:0] operatingMode,
  output logic timerIrq,
  // Input sources and selected input.
  input wire logic timerInPin,
  input wire logic comparatorOut,
  output logic timerInput,
  // Output pair.
  output logic timerOut,
  output logic timerOutN
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must hold the register offset");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Classifies a mode: 0 plain, 1 gated, 2 capture family.
  function automatic logic [1:0] modeKind(input logic [3:0] m);
    logic [1:0] k;
    k = 2'h0;
    case (m)
      tzc_pkg::MODE_GATED: k = 2'h1;
      tzc_pkg::MODE_CAPTURE, tzc_pkg::MODE_CAP_CMP,
      tzc_pkg::MODE_CAP_RESTART: k = 2'h2;
      default: k = 2'h0;
    endcase
    return k;
  endfunction

  // Decodes the delay field into a cycle count.
  function automatic logic [7:0] deadCycles(input logic [2:0] code);
    logic [7:0] c;
    c = 8'h00;
    if (code != 3'h0) begin
      c = 8'(1) << code;
    end
    return c;
  endfunction

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  tzc_pkg::tzc_ctl_t ctl_q;
  logic [3:0] modeNow;
  logic [1:0] kind;
  logic ctlHit;
  logic gateEdge;
  logic irqReload;
  logic irqCapture;
  logic irqOther;
  logic irqNow;

  assign ctlHit = (regAddr == ADDR_W'(tzc_pkg::CTL0_ADDR));
  assign modeNow = {ctl_q.modeHigh, modeLow};
  assign kind = modeKind(modeNow);

  // Writable fields; the capture flag bit of the write is dropped.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= tzc_pkg::CTL0_RESET;
    end else begin
      if (regWrEn && ctlHit) begin
        ctl_q.modeHigh <= regWrData[7];
        ctl_q.irqCfg <= regWrData[6:5];
        ctl_q.inSel <= regWrData[4];
        ctl_q.delay <= regWrData[3:1];
      end
      if (irqNow) begin
        ctl_q.capFlag <= irqCapture;
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn && ctlHit) begin
      regRdData <= ctl_q;
    end else begin
      regRdData <= 8'h00;
    end
  end

  // Mode selector to the datapath.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      operatingMode <= 4'h0;
    end else begin
      operatingMode <= modeNow;
    end
  end

  // ----------------------------------------
  // Input synchronisers and selection
  // ----------------------------------------
  logic [1:0] pinSync_q;
  logic [1:0] cmpSync_q;
  logic selIn;
  logic prevIn_q;

  // Two flops per asynchronous source.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinSync_q <= 2'h0;
      cmpSync_q <= 2'h0;
    end else begin
      pinSync_q <= {pinSync_q[0], timerInPin};
      cmpSync_q <= {cmpSync_q[0], comparatorOut};
    end
  end

  assign selIn = ctl_q.inSel ? cmpSync_q[1] : pinSync_q[1];

  // Selected input and its previous value for edge detection.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerInput <= 1'b0;
      prevIn_q <= 1'b0;
    end else begin
      timerInput <= selIn;
      prevIn_q <= timerInput;
    end
  end

  // Inactive gate edge: falling for polarity 0, rising for polarity 1.
  assign gateEdge = (kind == 2'h1) &&
                    (ioPolarity ? (timerInput && !prevIn_q)
                                : (!timerInput && prevIn_q));

  // ----------------------------------------
  // Interrupt selection
  // ----------------------------------------

  // Per-mode sources of an interrupt request.
  always_comb begin
    irqReload = 1'b0;
    irqCapture = 1'b0;
    irqOther = 1'b0;
    case (kind)
      2'h1: begin
        irqReload = evt.reload && (ctl_q.irqCfg != tzc_pkg::IRQ_CFG_ALT);
        irqOther = gateEdge && (ctl_q.irqCfg != tzc_pkg::IRQ_CFG_RELOAD);
      end
      2'h2: begin
        irqReload = evt.reload && (ctl_q.irqCfg != tzc_pkg::IRQ_CFG_ALT);
        irqCapture = evt.capture && (ctl_q.irqCfg != tzc_pkg::IRQ_CFG_RELOAD);
      end
      default: begin
        irqReload = evt.reload && (ctl_q.irqCfg != tzc_pkg::IRQ_CFG_ALT);
      end
    endcase
  end

  assign irqNow = irqReload || irqCapture || irqOther;

  // One-cycle interrupt request pulse.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= irqNow;
    end
  end

  // ----------------------------------------
  // Dead-time output pair
  // ----------------------------------------
  logic phase_q;
  logic [7:0] waitCnt_q;
  logic newPhase;
  logic swap;
  logic [7:0] dly;

  // Reload makes the output side active, a match the complement side.
  assign newPhase = evt.reload;
  assign swap = (evt.reload || evt.pwmMatch) && (newPhase != phase_q);
  assign dly = deadCycles(ctl_q.delay);

  // Drop at once, raise the other side after the programmed gap.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
      waitCnt_q <= 8'h00;
      timerOut <= 1'b0;
      timerOutN <= 1'b0;
    end else if (swap) begin
      phase_q <= newPhase;
      waitCnt_q <= dly;
      timerOut <= newPhase && (dly == 8'h00);
      timerOutN <= !newPhase && (dly == 8'h00);
    end else if (waitCnt_q != 8'h00) begin
      waitCnt_q <= waitCnt_q - 8'h01;
      if (waitCnt_q == 8'h01) begin
        timerOut <= phase_q;
        timerOutN <= !phase_q;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_mode_select: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (regWrEn && ctlHit) |=> ##1 operatingMode[3] == $past(regWrData[7], 2))
    else $error("Mode high bit not forwarded");

  a_cfg_store: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (regWrEn && ctlHit) |=> ctl_q.irqCfg == $past(regWrData[6:5]))
    else $error("Interrupt config not stored");

  a_plain_irq: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (kind == 2'h0 && evt.reload) |=>
    timerIrq == ($past(ctl_q.irqCfg) != tzc_pkg::IRQ_CFG_ALT))
    else $error("Plain mode reload interrupt wrong");

  a_gate_irq: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (gateEdge && !evt.reload) |=>
    timerIrq == ($past(ctl_q.irqCfg) != tzc_pkg::IRQ_CFG_RELOAD))
    else $error("Gate edge interrupt wrong");

  a_capture_irq: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (kind == 2'h2 && evt.capture && ctl_q.irqCfg != tzc_pkg::IRQ_CFG_RELOAD)
    |=> timerIrq && ctl_q.capFlag)
    else $error("Capture interrupt or flag missing");

  a_reload_clear: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (irqReload && !evt.capture && !irqOther) |=> !ctl_q.capFlag)
    else $error("Capture flag not cleared");

  a_flag_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (regWrEn && ctlHit && !irqNow) |=> $stable(ctl_q.capFlag))
    else $error("Capture flag changed by write");

  a_input_pick: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ctl_q.inSel && $stable(ctl_q.inSel) |=>
    timerInput == $past(cmpSync_q[1]))
    else $error("Comparator input not selected");

  a_no_overlap: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !(timerOut && timerOutN))
    else $error("Output and complement both active");

  // A new swap inside the gap restarts the count, so only undisturbed gaps are timed.
  a_gap_two: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (swap && !newPhase && ctl_q.delay == 3'h1) ##1 !swap ##1 !swap |->
    (!$past(timerOutN) && !timerOutN) ##1 timerOutN)
    else $error("Two-cycle dead time wrong");

  a_gap_load: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (swap && ctl_q.delay != 3'h0) |=> waitCnt_q == (8'h01 << $past(ctl_q.delay)))
    else $error("Dead time count not loaded");

  a_drop_now: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    swap |=> (phase_q ? !timerOutN : !timerOut))
    else $error("Outgoing side not dropped at once");

  a_read_back: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (regRdEn && ctlHit) |=> regRdData == $past(ctl_q))
    else $error("Register read data wrong");

  a_plain_other: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (kind == 2'h0 && !evt.reload) |=> !timerIrq)
    else $error("Plain mode interrupt without reload");

  a_gate_alt: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (kind == 2'h1 && ctl_q.irqCfg == tzc_pkg::IRQ_CFG_ALT && !gateEdge) |=> !timerIrq)
    else $error("Gated mode reload interrupt not suppressed");

  a_capture_only: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (kind == 2'h2 && ctl_q.irqCfg == tzc_pkg::IRQ_CFG_RELOAD && !evt.reload) |=> !timerIrq)
    else $error("Capture interrupt not suppressed");

  a_input_pin: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !ctl_q.inSel && $stable(ctl_q.inSel) |=>
    timerInput == $past(pinSync_q[1]))
    else $error("Pin input not selected");

  a_zero_gap: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (swap && ctl_q.delay == 3'h0) |=> (timerOut == phase_q) && (timerOutN == !phase_q))
    else $error("Zero delay transition late");

endmodule

`default_nettype wire

// ---- dv/tzc_timer_config_tb.sv ----
// Purpose: Self-checking bench for the timer configuration slice.
// Assumes: Events are single-cycle pulses driven just after the rising edge.
// Notes: Tasks and small functions model interrupts, capture flag and dead time.

`timescale 1ns/1ps
`default_nettype none

module tb;
  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] regAddr = '0;
  logic [7:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [2:0] modeLow = '0;
  logic ioPolarity = 1'b0;
  tzc_pkg::tzc_evt_t evt = '0;
  logic timerInPin = 1'b0;
  logic comparatorOut = 1'b0;
  logic [7:0] regRdData;
  logic [3:0] operatingMode;
  logic timerIrq, timerInput, timerOut, timerOutN;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] ctl;
  logic [7:0] rd;
  logic flag;
  logic b;

  tzc_timer_config DUT (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .modeLow(modeLow), .ioPolarity(ioPolarity),
    .evt(evt), .operatingMode(operatingMode), .timerIrq(timerIrq), .timerInPin(timerInPin),
    .comparatorOut(comparatorOut), .timerInput(timerInput), .timerOut(timerOut), .timerOutN(timerOutN));

  // Clock of 40 ns period.
  always #20 core_clk = ~core_clk;

  // Cycle ceiling cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // Tasks and model
  // ----------------------------------------
  // Compares a seen value with its expectation.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp=%h seen=%h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd8(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  // Drives one event for one cycle; returns at the edge that samples it.
  task automatic pulse(input tzc_pkg::tzc_evt_t e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
  endtask

  // Modes whose interrupts can come from capture.
  function automatic bit capMode(int m);
    return m == 4 || m == 7 || m == 9;
  endfunction

  // Expected interrupt for a mode, setting and event mix.
  function automatic bit irqExp(int m, int c, bit rl, bit cp);
    return (rl && c != 2) || (capMode(m) && cp && c != 3);
  endfunction

  // Fires an event and checks the one-cycle interrupt pulse.
  task automatic fire(input tzc_pkg::tzc_evt_t e, input bit exp);
    pulse(e);
    #1 check("irq", timerIrq, exp);
    @(posedge core_clk);
    #1 check("irqPulse", timerIrq, 1'b0);
  endtask

  // Counts interrupt pulses over a window after a gate change.
  task automatic gateWin(input bit exp);
    int n = 0;
    repeat (10) begin
      @(posedge core_clk);
      #1 n += timerIrq;
    end
    check("gateIrq", n[7:0], exp);
  endtask

  // Swaps the output pair and measures the dead gap.
  task automatic dead(input bit toN, input int d);
    int k = 0;
    pulse(toN ? 3'b001 : 3'b100);
    #1 check("dropOther", toN ? timerOut : timerOutN, 1'b0);
    while ((toN ? timerOutN : timerOut) !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      #1 k++;
    end
    check("deadTime", k[7:0], d[7:0]);
    check("otherOff", toN ? timerOut : timerOutN, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Reset, register access, interrupt table, gate, input select, dead time.
  initial begin
    void'($urandom(86));
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd8(12'hf06, rd);
    check("ctlReset", rd, tzc_pkg::CTL0_RESET);
    wr(12'hf07, 8'haa);
    rd8(12'hf07, rd);
    check("unmapped", rd, 8'h00);
    flag = 1'b0;
    for (int m = 0; m < 12; m++) begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 1; k < 4; k++) begin
          ctl = 8'($urandom());
          ctl[7] = m[3];
          ctl[6:5] = c[1:0];
          modeLow <= m[2:0];
          wr(12'hf06, ctl);
          fire({k[1], k[0], 1'b0}, irqExp(m, c, k[1], k[0]));
          if (irqExp(m, c, k[1], k[0])) begin
            flag = capMode(m) && k[0] && c != 3;
          end
          rd8(12'hf06, rd);
          check("ctl", rd, {ctl[7:1], flag});
          check("mode", operatingMode, {4'h0, m[3:0]});
          @(posedge core_clk);
          #1 check("rdIdle", regRdData, 8'h00);
        end
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        ioPolarity <= p[0];
        timerInPin <= !p[0];
        modeLow <= 3'h6;
        wr(12'hf06, {1'b0, c[1:0], 5'h00});
        gateWin(1'b0);
        timerInPin <= p[0];
        gateWin(c != 3);
        check("inputPin", timerInput, p[0]);
      end
    end
    modeLow <= 3'h3;
    wr(12'hf06, 8'h10);
    repeat (4) begin
      b = 1'($urandom());
      comparatorOut <= b;
      timerInPin <= !b;
      repeat (5) @(posedge core_clk);
      #1 check("inputCmp", timerInput, b);
    end
    pulse(3'b001);
    pulse(3'b100);
    for (int c = 0; c < 8; c++) begin
      wr(12'hf06, {4'h0, c[2:0], 1'b0});
      dead(1'b1, c == 0 ? 0 : 1 << c);
      dead(1'b0, c == 0 ? 0 : 1 << c);
    end
    final_report();
  end
endmodule

`default_nettype wire
